// ---- hdl/srd_rx_dma.sv ----
/*
 * receive descriptor dma channel: fetches slots, stores packet bytes,
 * writes back status and advances the selector.
 * assumes a memory master port whose ack comes on this clock and a
 * character stream from the link logic on the same clock.
 */
`timescale 1ns/1ns
module srd_rx_dma #(
  parameter bit BYTE_GRAN = 1'b0
) (
  // clock, reset, enable
  input wire logic clock,
  input wire logic resetn,
  input wire logic clk_en,
  // register port
  input wire logic [srd_pkg::SRD_ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // memory master
  output srd_pkg::srd_mem_req_t mem_req,
  input srd_pkg::srd_mem_rsp_t mem_rsp,
  // received characters
  input wire logic rx_valid,
  input srd_pkg::srd_rx_char_t rx_char,
  output logic rx_ready,
  // completion notice
  output logic rx_irq
);
  import srd_pkg::*;

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    srd_state_t state;
    logic allow;
    logic posted;
    logic irq_en;
    logic rcvd;
    logic buserr;
    logic [21:0] base;
    logic [6:0] sel;
    logic [24:0] maxlen;
    logic [31:0] rdata;
    logic notify;
    logic ret;
    logic [31:0] bptr;
    logic [24:0] count;
    logic [31:0] wbuf;
    logic [3:0] be;
    logic [29:0] wword;
    logic cut;
    logic pfail;
    logic hfail;
    logic eend;
    logic last_seen;
    logic irq;
  } srd_st_t;

  srd_st_t q;
  srd_st_t d;
  logic [31:0] word0;

  assign word0 = {q.cut, q.pfail, q.hfail, q.eend, q.notify, q.ret, 1'b0, q.count};

  // ****************************************
  // memory requests
  // ****************************************
  always_comb begin
    mem_req = '0;
    case (q.state)
      SRD_FETCH0: begin
        mem_req.valid = clk_en;
        mem_req.addr = srd_slot_addr(q.base, q.sel, 32'h00000000);
      end
      SRD_FETCH1: begin
        mem_req.valid = clk_en;
        mem_req.addr = srd_slot_addr(q.base, q.sel, SRD_D1_OFFSET);
      end
      SRD_WRITE: begin
        mem_req.valid = clk_en;
        mem_req.we = 1'b1;
        mem_req.addr = {q.wword, 2'b00};
        mem_req.wdata = q.wbuf;
        // whole word unless the byte option is built in
        mem_req.be = BYTE_GRAN ? q.be : 4'hF;
      end
      SRD_STATUS: begin
        mem_req.valid = clk_en;
        mem_req.we = 1'b1;
        mem_req.addr = srd_slot_addr(q.base, q.sel, 32'h00000000);
        mem_req.wdata = word0;
        mem_req.be = 4'hF;
      end
      default: begin
        mem_req = '0;
      end
    endcase
  end

  // held off while frozen so no character is taken and lost
  assign rx_ready = clk_en && (q.state == SRD_RECV || q.state == SRD_SPILL);
  assign reg_rdata = q.rdata;
  assign rx_irq = q.irq;

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    logic set_rcvd;
    logic set_err;
    logic clr_posted;
    logic room;
    logic [1:0] lane;
    logic [3:0] nbe;
    set_rcvd = 1'b0;
    set_err = 1'b0;
    clr_posted = 1'b0;
    room = q.count < q.maxlen;
    lane = q.bptr[1:0];
    nbe = q.be;
    d = q;
    d.irq = 1'b0;
    d.rdata = 32'h00000000;

    case (q.state)
      SRD_IDLE: begin
        // nothing moves until software allows it
        if (q.allow && q.posted && rx_valid) begin
          d.state = SRD_FETCH0;
          d.count = '0;
          d.cut = 1'b0;
          d.pfail = 1'b0;
          d.hfail = 1'b0;
          d.eend = 1'b0;
          d.last_seen = 1'b0;
          d.be = 4'h0;
          d.wbuf = 32'h00000000;
        end
      end
      SRD_FETCH0: begin
        if (mem_rsp.ack) begin
          if (mem_rsp.err) begin
            set_err = 1'b1;
            d.state = SRD_SPILL;
          end else if (!mem_rsp.rdata[SRD_D0_ARMED]) begin
            // packet stays queued until slots are posted again
            clr_posted = 1'b1;
            d.state = SRD_IDLE;
          end else begin
            d.notify = mem_rsp.rdata[SRD_D0_NOTIFY];
            d.ret = mem_rsp.rdata[SRD_D0_RETURN];
            d.state = SRD_FETCH1;
          end
        end
      end
      SRD_FETCH1: begin
        if (mem_rsp.ack) begin
          if (mem_rsp.err) begin
            set_err = 1'b1;
            d.state = SRD_SPILL;
          end else begin
            d.bptr = BYTE_GRAN ? mem_rsp.rdata : {mem_rsp.rdata[31:2], 2'b00};
            d.state = SRD_RECV;
          end
        end
      end
      SRD_RECV: begin
        if (rx_valid) begin
          if (rx_char.last) begin
            d.last_seen = 1'b1;
            d.eend = rx_char.eep;
            d.hfail = rx_char.head_err;
            d.pfail = rx_char.payload_err;
          end
          if (room) begin
            d.wbuf[lane*8 +: 8] = rx_char.data;
            nbe[lane] = 1'b1;
            d.be = nbe;
            d.wword = q.bptr[31:2];
            d.bptr = q.bptr + 32'h00000001;
            d.count = q.count + 25'h0000001;
          end else begin
            // excess bytes are dropped, only the flag remains
            d.cut = 1'b1;
          end
          if (nbe != 4'h0 && ((room && lane == 2'h3) || rx_char.last)) begin
            d.state = SRD_WRITE;
          end else if (rx_char.last) begin
            d.state = SRD_STATUS;
          end
        end
      end
      SRD_WRITE: begin
        if (mem_rsp.ack) begin
          d.be = 4'h0;
          d.wbuf = 32'h00000000;
          if (mem_rsp.err) begin
            set_err = 1'b1;
            d.state = q.last_seen ? SRD_IDLE : SRD_SPILL;
          end else begin
            d.state = q.last_seen ? SRD_STATUS : SRD_RECV;
          end
        end
      end
      SRD_STATUS: begin
        if (mem_rsp.ack) begin
          if (mem_rsp.err) begin
            set_err = 1'b1;
          end else begin
            set_rcvd = 1'b1;
            d.irq = q.notify && q.irq_en;
            // 7-bit selector rolls over at the table end by itself
            d.sel = q.ret ? 7'h00 : q.sel + 7'h01;
          end
          d.state = SRD_IDLE;
        end
      end
      SRD_SPILL: begin
        if (rx_valid && rx_char.last) begin
          d.state = SRD_IDLE;
        end
      end
      default: begin
        d.state = SRD_IDLE;
      end
    endcase

    // ****************************************
    // register writes
    // ****************************************
    if (clr_posted) begin
      d.posted = 1'b0;
    end
    if (set_err) begin
      // a bus fault shuts the channel until software re-enables it
      d.allow = 1'b0;
    end
    if (reg_wr) begin
      case (reg_addr)
        SRD_REG_CTRL: begin
          d.allow = reg_wdata[SRD_CTRL_ALLOW];
          d.posted = reg_wdata[SRD_CTRL_POSTED];
          d.irq_en = reg_wdata[SRD_CTRL_IRQEN];
          if (reg_wdata[SRD_CTRL_RCVD]) begin
            d.rcvd = 1'b0;
          end
          if (reg_wdata[SRD_CTRL_BUSERR]) begin
            d.buserr = 1'b0;
          end
        end
        SRD_REG_TABLE: begin
          d.base = reg_wdata[31:SRD_TBL_BASE_LSB];
          d.sel = reg_wdata[SRD_TBL_BASE_LSB-1:SRD_SEL_LSB];
        end
        SRD_REG_MAXLEN: begin
          d.maxlen = {reg_wdata[SRD_LEN_W-1:2], 2'b00};
        end
        default: begin
          d.maxlen = d.maxlen;
        end
      endcase
    end
    // hardware events win over a clear in the same cycle
    if (set_rcvd) begin
      d.rcvd = 1'b1;
    end
    if (set_err) begin
      d.buserr = 1'b1;
    end

    // ****************************************
    // register reads
    // ****************************************
    if (reg_rd) begin
      case (reg_addr)
        SRD_REG_CTRL: begin
          d.rdata[SRD_CTRL_ALLOW] = q.allow;
          d.rdata[SRD_CTRL_POSTED] = q.posted;
          d.rdata[SRD_CTRL_IRQEN] = q.irq_en;
          d.rdata[SRD_CTRL_ACTIVE] = q.state != SRD_IDLE;
          d.rdata[SRD_CTRL_RCVD] = q.rcvd;
          d.rdata[SRD_CTRL_BUSERR] = q.buserr;
        end
        SRD_REG_TABLE: begin
          d.rdata = {q.base, q.sel, 3'h0};
        end
        SRD_REG_MAXLEN: begin
          d.rdata = {7'h00, q.maxlen};
        end
        default: begin
          d.rdata = 32'h00000000;
        end
      endcase
    end
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      q <= '0;
      q.state <= SRD_IDLE;
      q.maxlen <= SRD_MAXLEN_RESET;
    end else if (clk_en) begin
      q <= d;
    end
  end

endmodule : srd_rx_dma

// ---- hdl/srd_pkg.sv ----
/*
 * constants and types of the spacewire receive descriptor dma channel.
 * assumes one system clock; the memory port and the character stream
 * come from logic on that clock.
 */
// What this block does
// - the table is one kilobyte: at most 128 slots of eight bytes.
// - after a slot is consumed the selector advances by one slot.
// - passing the last slot wraps the selector back to the table base.
// - return-to-base flag sends the next fetch to slot zero, else step 0x8.
// - selector may start mid-table at any 8-byte aligned value; wrap still applies.
// - completion interrupt only when slot notify bit and interrupt enable are set.
// - without byte option, buffers get whole-word writes, final partial word too.
// - with byte option, any alignment and only received bytes are written.
// - bit 31 of word 0 reports truncation at the channel maximum length.
// - bit 30 of word 0 reports a payload check error, zero otherwise.
// - head check fail flag reports a header check error, zero otherwise.
// - error end flag reports a packet ended by an error end marker.
// - received byte count holds bytes stored; valid once slot-armed is clear.
// - word 1 is the buffer pointer; low two bits ignored without byte option.
// - no reception activity at all until receive-allow is set.
// - with receive-allow and slots-posted set, storing starts when data arrives.
// - a fully stored packet clears slot-armed, validating status and count.
// - an unarmed slot clears slots-posted and stops fetching until set again.
// - packets beyond the maximum length are cut, excess dropped, and reported.
package srd_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam int unsigned SRD_ADDR_W = 8;
  localparam logic [7:0] SRD_REG_CTRL = 8'h00;
  localparam logic [7:0] SRD_REG_TABLE = 8'h04;
  localparam logic [7:0] SRD_REG_MAXLEN = 8'h08;

  localparam int unsigned SRD_CTRL_ALLOW = 0;
  localparam int unsigned SRD_CTRL_POSTED = 1;
  localparam int unsigned SRD_CTRL_IRQEN = 2;
  localparam int unsigned SRD_CTRL_ACTIVE = 3;
  localparam int unsigned SRD_CTRL_RCVD = 4;
  localparam int unsigned SRD_CTRL_BUSERR = 5;

  localparam int unsigned SRD_TBL_BASE_LSB = 10;
  localparam int unsigned SRD_SEL_LSB = 3;
  localparam int unsigned SRD_SEL_W = 7;
  localparam int unsigned SRD_LEN_W = 25;
  localparam logic [24:0] SRD_MAXLEN_RESET = 25'h1FFFFFC;

  // ****************************************
  // slot word 0 fields
  // ****************************************
  localparam int unsigned SRD_D0_CUT = 31;
  localparam int unsigned SRD_D0_PAYLOAD = 30;
  localparam int unsigned SRD_D0_HEAD = 29;
  localparam int unsigned SRD_D0_EEND = 28;
  localparam int unsigned SRD_D0_NOTIFY = 27;
  localparam int unsigned SRD_D0_RETURN = 26;
  localparam int unsigned SRD_D0_ARMED = 25;
  localparam logic [31:0] SRD_D1_OFFSET = 32'h00000004;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [2:0] {
    SRD_IDLE, SRD_FETCH0, SRD_FETCH1, SRD_RECV, SRD_WRITE, SRD_STATUS, SRD_SPILL
  } srd_state_t;

  typedef struct packed {
    logic valid;
    logic we;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [3:0] be;
  } srd_mem_req_t;

  typedef struct packed {
    logic ack;
    logic err;
    logic [31:0] rdata;
  } srd_mem_rsp_t;

  typedef struct packed {
    logic [7:0] data;
    logic last;
    logic eep;
    logic head_err;
    logic payload_err;
  } srd_rx_char_t;

  // slot address: base plus selector times eight plus word offset
  function automatic logic [31:0] srd_slot_addr(input logic [21:0] base,
                                                input logic [6:0] sel,
                                                input logic [31:0] off);
    srd_slot_addr = {base, sel, 3'h0} + off;
  endfunction : srd_slot_addr

endpackage : srd_pkg

// ---- verif/srd_rx_dma_props.sv ----
/* port checker of the receive descriptor channel.
   assumes one clock domain; the bind hands on BYTE_GRAN. */
`timescale 1ns/1ns
module srd_rx_dma_props import srd_pkg::*; #(
  parameter bit BYTE_GRAN = 1'b0
) (
  // clock, reset, enable
  input wire logic clock,
  input wire logic resetn,
  input wire logic clk_en,
  // register port
  input wire logic [srd_pkg::SRD_ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  // memory and stream
  input srd_pkg::srd_mem_req_t mem_req,
  input srd_pkg::srd_mem_rsp_t mem_rsp,
  input wire logic rx_valid,
  input srd_pkg::srd_rx_char_t rx_char,
  input wire logic rx_ready,
  input wire logic rx_irq
);
  // ****
  // helpers
  // ****
  logic seen_q;
  logic [21:0] base_q;
  logic sts_ack;
  // table base never moves by hardware, so a shadow is exact
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      seen_q <= 1'b0;
      base_q <= '0;
    end else if (reg_wr && clk_en) begin
      if (reg_addr == SRD_REG_CTRL && reg_wdata[SRD_CTRL_ALLOW]) seen_q <= 1'b1;
      if (reg_addr == SRD_REG_TABLE) base_q <= reg_wdata[31:10];
    end
  end
  assign sts_ack = mem_req.valid && mem_req.we && mem_rsp.ack &&
                   mem_req.addr[31:10] == base_q && mem_req.addr[2:0] == 3'h0;
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  // ****
  // assertions
  // ****
  idle_until_allow_a: assert property (mem_req.valid |-> seen_q)
    else $error("memory request before receive allow");
  slot_in_table_a: assert property (mem_req.valid && !mem_req.we |->
    mem_req.addr[31:10] == base_q)
    else $error("slot read outside the table");
  // a faulted first word ends the slot, so only a clean answer demands the second read
  word_pair_a: assert property (mem_req.valid && !mem_req.we && mem_rsp.ack &&
    !mem_rsp.err && mem_req.addr[2:0] == 3'h0 && mem_rsp.rdata[SRD_D0_ARMED] |=>
    mem_req.valid && !mem_req.we && mem_req.addr == $past(mem_req.addr) + 32'h4)
    else $error("second slot word not fetched next");
  whole_word_a: assert property (BYTE_GRAN == 1'b0 && mem_req.valid && mem_req.we |->
    mem_req.be == 4'hF && mem_req.addr[1:0] == 2'h0)
    else $error("partial or unaligned write");
  req_hold_a: assert property (clk_en && mem_req.valid && !mem_rsp.ack |=>
    mem_req.valid && $stable(mem_req.addr) && $stable(mem_req.wdata))
    else $error("memory request dropped before ack");
  stall_fetch_a: assert property (rx_ready |-> !mem_req.valid)
    else $error("stream taken during memory access");
  irq_cause_a: assert property (rx_irq |-> $past(sts_ack))
    else $error("completion notice without status write");
  irq_pulse_a: assert property (rx_irq |=> !rx_irq)
    else $error("completion notice longer than one cycle");
  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside its cycle");
  cover property (sts_ack);
  cover property (rx_irq);
  cover property (rx_valid && rx_ready && rx_char.last);
endmodule : srd_rx_dma_props

bind srd_rx_dma srd_rx_dma_props #(.BYTE_GRAN(BYTE_GRAN)) srd_rx_dma_props_inst (
  .clock(clock), .resetn(resetn), .clk_en(clk_en), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .mem_req(mem_req), .mem_rsp(mem_rsp), .rx_valid(rx_valid), .rx_char(rx_char),
  .rx_ready(rx_ready), .rx_irq(rx_irq));

// ---- verif/srd_mem_model.sv ----
/* system memory behind the channel's master port, 4 kbyte.
   assumes one request at a time; wt sets wait cycles before ack. */
`timescale 1ns/1ns
module srd_mem_model import srd_pkg::*; (
  // clock and port
  input wire logic clock,
  input srd_pkg::srd_mem_req_t req,
  output srd_pkg::srd_mem_rsp_t rsp
);
  logic [31:0] mem [0:1023];
  int wt = 0;
  int cnt = 0;
  initial rsp = '0;
  always @(posedge clock) begin
    if (req.valid && !rsp.ack && cnt >= wt) begin
      rsp.ack <= 1'b1;
      rsp.rdata <= mem[req.addr[11:2]];
      cnt <= 0;
      for (int i = 0; i < 4; i++) begin
        if (req.we && req.be[i]) mem[req.addr[11:2]][8*i+:8] <= req.wdata[8*i+:8];
      end
    end else begin
      rsp.ack <= 1'b0;
      // no stale data between answers
      rsp.rdata <= ~rsp.rdata;
      if (req.valid && !rsp.ack) cnt <= cnt + 1;
    end
  end
endmodule : srd_mem_model

// ---- verif/srd_rx_dma_test.sv ----
/* self-checking bench of the receive descriptor channel.
   assumes table at 0x400 and buffers from 0x800 in the memory model. */
`timescale 1ns/1ns
module srd_rx_dma_test;
  import srd_pkg::*;
  logic clock, resetn, clk_en, reg_wr, reg_rd, rx_valid, rx_ready, rx_irq;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, v;
  srd_mem_req_t mem_req;
  srd_mem_rsp_t mem_rsp;
  srd_rx_char_t rx_char;
  int n_errors = 0, checks_done = 0, n_irq = 0, ticks = 0;
  srd_rx_dma srd_rx_dma_inst (.clock(clock), .resetn(resetn), .clk_en(clk_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .mem_req(mem_req), .mem_rsp(mem_rsp), .rx_valid(rx_valid),
    .rx_char(rx_char), .rx_ready(rx_ready), .rx_irq(rx_irq));
  srd_mem_model srd_mem_model_inst (.clock(clock), .req(mem_req), .rsp(mem_rsp));
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  always @(posedge clock) begin
    ticks++;
    if (rx_irq === 1'b1) n_irq++;
    if (ticks == 20000) begin
      n_errors++;
      wrap_up();
    end
  end
  // ****
  // tasks
  // ****
  function automatic logic [31:0] m(input int i);
    return srd_mem_model_inst.mem[i];
  endfunction : m
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task wr(input logic [7:0] a, input logic [31:0] d);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
    @(posedge clock);
  endtask : wr
  task rd(input logic [7:0] a, input logic [31:0] e);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    // data stand only in this cycle; sample it mid-cycle, away from the edges
    @(negedge clock);
    v = reg_rdata;
    @(posedge clock);
    if (e !== 32'hFFFFFFFF) chk(v, e);
  endtask : rd
  // arm a slot: pointer first, armed bit last
  task arm(input int i, input logic [31:0] w0, input logic [31:0] p);
    srd_mem_model_inst.mem[257+2*i] = p;
    srd_mem_model_inst.mem[256+2*i] = w0;
  endtask : arm
  // byte k carries 0x10+k; flags eep, head, payload ride on the last byte
  task send(input int n, input logic [2:0] f);
    int w;
    for (int k = 0; k < n; k++) begin
      rx_valid <= 1'b1;
      rx_char <= {8'h10 + 8'(k), k == n - 1, f & {3{k == n - 1}}};
      w = 0;
      @(posedge clock);
      while (rx_ready !== 1'b1 && w < 400) begin
        w++;
        @(posedge clock);
      end
    end
    rx_valid <= 1'b0;
    rx_char <= 12'hA5A;
  endtask : send
  task done(input int i);
    int w;
    w = 0;
    while (srd_mem_model_inst.mem[256 + 2 * i][SRD_D0_ARMED] !== 1'b0 && w < 500) begin
      w++;
      @(posedge clock);
    end
    repeat (3) @(posedge clock);
  endtask : done
  task wrap_up;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : wrap_up
  // ****
  // sequence
  // ****
  initial begin
    resetn = 1'b0;
    clk_en = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    rx_valid = 1'b0;
    rx_char = '0;
    repeat (5) @(posedge clock);
    resetn <= 1'b1;
    rd(SRD_REG_CTRL, 32'h0);
    rd(SRD_REG_MAXLEN, 32'h1FFFFFC);
    wr(8'h0C, 32'hFFFFFFFF);
    rd(8'h0C, 32'h0);
    wr(SRD_REG_TABLE, 32'h000007F7);
    rd(SRD_REG_TABLE, 32'h000007F0);
    arm(126, 32'h0A000000, 32'h00000803);
    wr(SRD_REG_CTRL, 32'h2);
    fork
      send(6, 3'b001);
      begin
        repeat (20) @(posedge clock);
        chk(m(508), 32'h0A000000);
        wr(SRD_REG_CTRL, 32'h7);
      end
    join
    done(126);
    chk(m(512), 32'h13121110);
    chk(m(513), 32'h00001514);
    chk(m(508), 32'h48000006);
    rd(SRD_REG_TABLE, 32'h000007F8);
    chk(32'(n_irq), 32'h1);
    arm(127, 32'h0A000000, 32'h00000900);
    srd_mem_model_inst.mem[577] = 32'hC3C3C3C3;
    srd_mem_model_inst.wt = 2;
    wr(SRD_REG_MAXLEN, 32'h4);
    wr(SRD_REG_CTRL, 32'h3);
    send(7, 3'b100);
    done(127);
    chk(m(576), 32'h13121110);
    chk(m(577), 32'hC3C3C3C3);
    chk(m(510), 32'h98000004);
    rd(SRD_REG_TABLE, 32'h00000400);
    chk(32'(n_irq), 32'h1);
    srd_mem_model_inst.wt = 0;
    arm(0, 32'h06000000, 32'h00000A00);
    wr(SRD_REG_MAXLEN, 32'h100);
    wr(SRD_REG_CTRL, 32'h3);
    send(3, 3'b010);
    done(0);
    chk(m(640), 32'h00121110);
    chk(m(256), 32'h24000003);
    rd(SRD_REG_TABLE, 32'h00000400);
    wr(SRD_REG_CTRL, 32'h3);
    fork
      send(2, 3'b000);
      begin
        repeat (30) @(posedge clock);
        rd(SRD_REG_CTRL, 32'h00000011);
        chk({31'h0, v[SRD_CTRL_POSTED]}, 32'h0);
        arm(0, 32'h02000000, 32'h00000A40);
        wr(SRD_REG_CTRL, 32'h3);
      end
    join
    done(0);
    chk(m(256), 32'h00000002);
    chk(m(656), 32'h00001110);
    // table switch: stop, see idle, then move the table
    wr(SRD_REG_CTRL, 32'h0);
    rd(SRD_REG_CTRL, 32'h00000010);
    wr(SRD_REG_TABLE, 32'h00000C00);
    rd(SRD_REG_TABLE, 32'h00000C00);
    wr(SRD_REG_CTRL, 32'h00000010);
    rd(SRD_REG_CTRL, 32'h0);
    // a write while frozen is lost
    clk_en <= 1'b0;
    wr(SRD_REG_TABLE, 32'h00000400);
    clk_en <= 1'b1;
    rd(SRD_REG_TABLE, 32'h00000C00);
    // reset in mid-run brings back the reset values
    resetn <= 1'b0;
    @(posedge clock);
    resetn <= 1'b1;
    rd(SRD_REG_TABLE, 32'h0);
    rd(SRD_REG_MAXLEN, 32'h1FFFFFC);
    wrap_up();
  end
endmodule : srd_rx_dma_test
